// ==== hdl/flash_pins_pkg.sv ====
package flash_pins_pkg;

	// Byte layout of the serial stream, most significant bit first.
	localparam int BYTE_W = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int MSB = 7;
	localparam int NIB_LO = 4;
	localparam int PAIR_LO = 6;

	// Instruction codes seen by the lane logic.
	localparam logic [7:0] CMD_WRITE = 8'h01;
	localparam logic [7:0] CMD_READ_ONE = 8'h02;
	localparam logic [7:0] CMD_READ_TWO = 8'h03;
	localparam logic [7:0] CMD_READ_FOUR = 8'h04;
	localparam logic [7:0] CMD_STATUS = 8'h05;

	// Output enable patterns over lanes 3..0.
	localparam logic [3:0] OE_NONE = 4'h0;
	localparam logic [3:0] OE_ONE = 4'h2;
	localparam logic [3:0] OE_TWO = 4'h3;
	localparam logic [3:0] OE_FOUR = 4'hF;

	// Bits moved per falling edge, and bits in one byte.
	localparam logic [3:0] STEP_ONE = 4'h1;
	localparam logic [3:0] STEP_TWO = 4'h2;
	localparam logic [3:0] STEP_FOUR = 4'h4;
	localparam logic [3:0] BITS_FULL = 4'h8;
	localparam logic [3:0] LEFT_NONE = 4'h0;

	// Status byte padding above the busy bit.
	localparam logic [6:0] STAT_PAD = 7'h00;

	// Synchroniser reset values; chip select is caught low so that
	// arming needs a real high level after reset.
	localparam logic [3:0] LSYNC_RST = 4'h0;
	localparam logic [3:0] MSYNC_RST = 4'h8;

	// Width of the internal cycle counter.
	localparam int BUSY_W = 16;

	// Link-side transaction phases, one-hot.
	typedef enum logic [6:0] {
		ST_CMD = 7'h01,
		ST_WRITE = 7'h02,
		ST_RD1 = 7'h04,
		ST_RD2 = 7'h08,
		ST_RD4 = 7'h10,
		ST_STAT = 7'h20,
		ST_IGN = 7'h40
	} link_state_e;

endpackage

// ==== hdl/serial_flash_pin_interface.sv ====
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - Chip select high: deselected, all lanes released.
// R2 - Chip select low: take instructions, return data.
// R3 - Ignore instructions until a chip select fall.
// R4 - Internal cycle runs on after deselect.
// R5 - Single lane: sample lane 0 on rise.
// R6 - Single lane: drive lane 1 on fall.
// R7 - Multi lane: sample rise, drive fall.
// R8 - Four-lane instructions need four_lane_enable.
// R9 - Enable set: lanes 2, 3 become data.
// R10 - Two-lane uses lanes 0-1, four-lane 0-3.
// R11 - Hold honoured only outside four-lane use.
// R12 - Reset input acts in every state.
// R13 - Hold low: release output, ignore clock.
// R14 - Drive lanes only in read phase.
module serial_flash_pin_interface #(
	parameter logic [flash_pins_pkg::BUSY_W-1:0] BUSY_CYCLES = 16'h03E8
) (
	// System clock and reset.
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Serial link pins.
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic [3:0] data_lane_in,
	output logic [3:0] data_lane_out,
	output logic [3:0] data_lane_oe_out,
	// Configuration from the core.
	input wire logic four_lane_enable_in,
	// Read data supplied by the core.
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_load_in,
	output logic tx_ready_out,
	// Bytes received from the host.
	output logic [7:0] rx_byte_out,
	output logic rx_valid_out,
	output logic rx_is_cmd_out,
	// Core status.
	output logic busy_out,
	output logic write_protect_out
);

	////////////////////////////////////////////////////////////////////
	// Link domain state.

	// Frame logic is cleared whenever the chip is deselected.
	logic frame_rst;
	flash_pins_pkg::link_state_e st_ff; // Transaction phase.
	flash_pins_pkg::link_state_e nxt_st; // Phase after the command.
	logic [7:0] in_sh_ff; // Incoming bits.
	logic [7:0] nxt_byte; // Byte including this edge's bit.
	logic [2:0] bit_ff; // Bit index inside the byte.
	logic byte_done; // Last bit of a received byte.
	logic hold_n; // Low while the host pauses us.
	logic [7:0] rx_hold_ff; // Received byte for the core.
	logic rx_cmd_ff; // That byte was an instruction.
	logic rx_tgl_ff; // Flips once per received byte.
	logic [7:0] tx_buf_ff; // Read data in the link domain.
	logic tx_seen_ff; // Last core load taken.
	logic [7:0] out_sh_ff; // Outgoing bits.
	logic [3:0] out_left_ff; // Bits still to send.
	logic [3:0] lane_out_ff; // Lane levels.
	logic [3:0] lane_oe_ff; // Lane enables.
	logic [3:0] ls1_ff, ls2_ff, ls3_ff, lq_ff; // Link synchronisers.
	logic [3:0] l_agree; // Second and third stages agree.
	logic qe_l, armed_l, busy_l, txt_l; // Synchronised levels.

	////////////////////////////////////////////////////////////////////
	// Core domain state.

	logic [3:0] ms1_ff, ms2_ff, ms3_ff, mq_ff; // Core synchronisers.
	logic [3:0] m_agree; // Second and third stages agree.
	logic cs_m, rxt_m, ack_m, wp_n_m; // Synchronised levels.
	logic cs_prev_ff; // Chip select one cycle back.
	logic armed_ff; // A deselect was seen since reset.
	logic rx_seen_ff; // Last link toggle consumed.
	logic wr_pend_ff; // A write instruction is open.
	logic [flash_pins_pkg::BUSY_W-1:0] busy_cnt_ff; // Cycle timer.
	logic busy_ff; // Internal cycle running.
	logic [7:0] tx_hold_ff; // Byte offered to the link.
	logic tx_tgl_ff; // Flips once per core load.
	logic tx_ready_ff; // Link has taken the last load.
	logic [7:0] rx_byte_ff; // Byte shown to the core.
	logic rx_valid_ff; // One-cycle byte strobe.
	logic rx_is_cmd_ff; // Strobed byte was an instruction.
	logic wp_ff; // Write protect level.

	// A pin reset or a deselect both clear the frame.
	assign frame_rst = cs_n_in | ~resetn_in; // R1 R12

	// Lane 3 is a hold pin only while four-lane use is off.
	assign hold_n = data_lane_in[3] | qe_l | (st_ff == flash_pins_pkg::ST_RD4); // R9 R11

	assign nxt_byte = {in_sh_ff[flash_pins_pkg::MSB-1:0], data_lane_in[0]};
	assign byte_done = hold_n & (bit_ff == flash_pins_pkg::LAST_BIT) &
		((st_ff == flash_pins_pkg::ST_CMD) | (st_ff == flash_pins_pkg::ST_WRITE));

	assign qe_l = lq_ff[0];
	assign armed_l = lq_ff[1];
	assign busy_l = lq_ff[2];
	assign txt_l = lq_ff[3];
	assign l_agree = ~(ls2_ff ^ ls3_ff);

	assign cs_m = mq_ff[0];
	assign rxt_m = mq_ff[1];
	assign ack_m = mq_ff[2];
	assign wp_n_m = mq_ff[3];
	assign m_agree = ~(ms2_ff ^ ms3_ff);

	////////////////////////////////////////////////////////////////////
	// Instruction decode at the end of the command byte.

	always_comb begin
		nxt_st = flash_pins_pkg::ST_IGN;
		if (!armed_l) begin
			nxt_st = flash_pins_pkg::ST_IGN; // R3
		end else if (nxt_byte == flash_pins_pkg::CMD_WRITE) begin
			nxt_st = flash_pins_pkg::ST_WRITE;
		end else if (nxt_byte == flash_pins_pkg::CMD_READ_ONE) begin
			nxt_st = flash_pins_pkg::ST_RD1;
		end else if (nxt_byte == flash_pins_pkg::CMD_READ_TWO) begin
			nxt_st = flash_pins_pkg::ST_RD2;
		end else if (nxt_byte == flash_pins_pkg::CMD_READ_FOUR) begin
			// Without the enable the instruction is dropped.
			nxt_st = qe_l ? flash_pins_pkg::ST_RD4 : flash_pins_pkg::ST_IGN; // R8
		end else if (nxt_byte == flash_pins_pkg::CMD_STATUS) begin
			nxt_st = flash_pins_pkg::ST_STAT;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Rising edge: sample lane 0 into the shift register.

	always_ff @(posedge sclk_in or posedge frame_rst) begin
		if (frame_rst) begin
			st_ff <= flash_pins_pkg::ST_CMD;
			in_sh_ff <= 8'h00;
			bit_ff <= 3'h0;
		end else if (hold_n) begin // R13
			// Commands and write data come in on lane 0 only.
			if (st_ff == flash_pins_pkg::ST_CMD ||
				st_ff == flash_pins_pkg::ST_WRITE) begin // R2 R5 R7
				in_sh_ff <= nxt_byte;
				bit_ff <= bit_ff + 3'h1;
				if (st_ff == flash_pins_pkg::ST_CMD &&
					bit_ff == flash_pins_pkg::LAST_BIT) begin
					st_ff <= nxt_st;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link crossings; these survive deselect so no event is made up.

	always_ff @(posedge sclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_hold_ff <= 8'h00;
			rx_cmd_ff <= 1'b0;
			rx_tgl_ff <= 1'b0;
		end else if (byte_done) begin
			// The byte stays still for a whole byte time, which the
			// core needs to see the toggle through its synchroniser.
			rx_hold_ff <= nxt_byte;
			rx_cmd_ff <= (st_ff == flash_pins_pkg::ST_CMD);
			rx_tgl_ff <= ~rx_tgl_ff;
		end
	end

	// Read data is taken from the core once its toggle settles.
	always_ff @(posedge sclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_buf_ff <= 8'h00;
			tx_seen_ff <= 1'b0;
		end else if (txt_l != tx_seen_ff) begin
			tx_buf_ff <= tx_hold_ff;
			tx_seen_ff <= txt_l;
		end
	end

	// Three-stage synchronisers; a change counts once stages agree.
	always_ff @(posedge sclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ls1_ff <= flash_pins_pkg::LSYNC_RST;
			ls2_ff <= flash_pins_pkg::LSYNC_RST;
			ls3_ff <= flash_pins_pkg::LSYNC_RST;
			lq_ff <= flash_pins_pkg::LSYNC_RST;
		end else begin
			ls1_ff <= {tx_tgl_ff, busy_ff, armed_ff, four_lane_enable_in};
			ls2_ff <= ls1_ff;
			ls3_ff <= ls2_ff;
			lq_ff <= (ls3_ff & l_agree) | (lq_ff & ~l_agree);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Falling edge: drive read data, one to four bits at a time.

	logic [3:0] step;
	logic [3:0] oe_pat;
	logic [7:0] cur;

	always_comb begin
		step = flash_pins_pkg::STEP_ONE;
		oe_pat = flash_pins_pkg::OE_ONE; // R6
		if (st_ff == flash_pins_pkg::ST_RD2) begin
			step = flash_pins_pkg::STEP_TWO;
			oe_pat = flash_pins_pkg::OE_TWO; // R10
		end else if (st_ff == flash_pins_pkg::ST_RD4) begin
			step = flash_pins_pkg::STEP_FOUR;
			oe_pat = flash_pins_pkg::OE_FOUR; // R9 R10
		end
		// A new byte is fetched only on a byte boundary.
		if (out_left_ff != flash_pins_pkg::LEFT_NONE) begin
			cur = out_sh_ff;
		end else if (st_ff == flash_pins_pkg::ST_STAT) begin
			cur = {flash_pins_pkg::STAT_PAD, busy_l};
		end else begin
			cur = tx_buf_ff;
		end
	end

	always_ff @(negedge sclk_in or posedge frame_rst) begin
		if (frame_rst) begin
			lane_out_ff <= 4'h0;
			lane_oe_ff <= flash_pins_pkg::OE_NONE; // R1
			out_sh_ff <= 8'h00;
			out_left_ff <= flash_pins_pkg::LEFT_NONE;
		end else if (!hold_n) begin
			// Paused: release the lanes and keep the position.
			lane_oe_ff <= flash_pins_pkg::OE_NONE; // R13
		end else if (st_ff == flash_pins_pkg::ST_RD1 ||
			st_ff == flash_pins_pkg::ST_RD2 ||
			st_ff == flash_pins_pkg::ST_RD4 ||
			st_ff == flash_pins_pkg::ST_STAT) begin // R6 R7 R14
			lane_oe_ff <= oe_pat;
			if (st_ff == flash_pins_pkg::ST_RD4) begin
				lane_out_ff <= cur[flash_pins_pkg::MSB:flash_pins_pkg::NIB_LO];
			end else if (st_ff == flash_pins_pkg::ST_RD2) begin
				lane_out_ff <= {2'h0,
					cur[flash_pins_pkg::MSB:flash_pins_pkg::PAIR_LO]};
			end else begin
				lane_out_ff <= {2'h0, cur[flash_pins_pkg::MSB], 1'b0};
			end
			out_sh_ff <= cur << step;
			out_left_ff <= (out_left_ff == flash_pins_pkg::LEFT_NONE ?
				flash_pins_pkg::BITS_FULL : out_left_ff) - step;
		end else begin
			// Command and write phases belong to the host.
			lane_oe_ff <= flash_pins_pkg::OE_NONE; // R14
		end
	end

	assign data_lane_out = lane_out_ff;
	assign data_lane_oe_out = lane_oe_ff;

	////////////////////////////////////////////////////////////////////
	// Core domain synchronisers for pins and link toggles.

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ms1_ff <= flash_pins_pkg::MSYNC_RST;
			ms2_ff <= flash_pins_pkg::MSYNC_RST;
			ms3_ff <= flash_pins_pkg::MSYNC_RST;
			mq_ff <= flash_pins_pkg::MSYNC_RST;
		end else begin
			ms1_ff <= {data_lane_in[2], tx_seen_ff, rx_tgl_ff, cs_n_in};
			ms2_ff <= ms1_ff;
			ms3_ff <= ms2_ff;
			mq_ff <= (ms3_ff & m_agree) | (mq_ff & ~m_agree);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Power-up arming: a high chip select must be seen first.

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			armed_ff <= 1'b0;
			cs_prev_ff <= 1'b0;
		end else begin
			cs_prev_ff <= cs_m;
			if (cs_m) begin
				armed_ff <= 1'b1; // R3
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Received bytes, shown as a one-cycle strobe.

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_seen_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
			rx_is_cmd_ff <= 1'b0;
		end else begin
			rx_valid_ff <= 1'b0;
			if (rxt_m != rx_seen_ff) begin
				rx_seen_ff <= rxt_m;
				rx_byte_ff <= rx_hold_ff;
				rx_is_cmd_ff <= rx_cmd_ff;
				rx_valid_ff <= armed_ff; // R3
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Internal cycle: opened by a write, started at deselect, and
	// stopped by its own count or the reset pin, never by chip select.

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_pend_ff <= 1'b0;
			busy_cnt_ff <= '0;
			busy_ff <= 1'b0;
		end else begin
			if (rxt_m != rx_seen_ff && armed_ff && rx_cmd_ff) begin
				wr_pend_ff <= (rx_hold_ff == flash_pins_pkg::CMD_WRITE);
			end else if (cs_m && !cs_prev_ff) begin
				wr_pend_ff <= 1'b0;
			end
			if (cs_m && !cs_prev_ff && wr_pend_ff && !busy_ff) begin
				busy_cnt_ff <= BUSY_CYCLES;
				busy_ff <= 1'b1;
			end else if (busy_cnt_ff != '0) begin // R4
				busy_cnt_ff <= busy_cnt_ff - 1'b1;
				busy_ff <= (busy_cnt_ff != {{(flash_pins_pkg::BUSY_W-1){1'b0}},
					1'b1});
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data handshake toward the link.

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_hold_ff <= 8'h00;
			tx_tgl_ff <= 1'b0;
			tx_ready_ff <= 1'b0;
		end else if (tx_load_in && tx_ready_ff) begin
			// Loads while not ready are dropped; the held byte must
			// not move while the link may be copying it.
			tx_hold_ff <= tx_byte_in;
			tx_tgl_ff <= ~tx_tgl_ff;
			tx_ready_ff <= 1'b0;
		end else begin
			tx_ready_ff <= (ack_m == tx_tgl_ff);
		end
	end

	// The protect pin only matters while lane 2 is not data.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wp_ff <= 1'b0;
		end else begin
			wp_ff <= ~wp_n_m & ~four_lane_enable_in; // R9
		end
	end

	assign tx_ready_out = tx_ready_ff;
	assign rx_byte_out = rx_byte_ff;
	assign rx_valid_out = rx_valid_ff;
	assign rx_is_cmd_out = rx_is_cmd_ff;
	assign busy_out = busy_ff;
	assign write_protect_out = wp_ff;

endmodule

`default_nettype wire

// ==== tb/flash_pins_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

// Watches the pins and core flags of the serial flash lane block.
module flash_pins_assertions #(
	parameter logic [flash_pins_pkg::BUSY_W-1:0] BUSY_CYCLES = 16'h03E8
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Link pins.
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic [3:0] data_lane_in,
	input wire logic [3:0] data_lane_out,
	input wire logic [3:0] data_lane_oe_out,
	// Core side.
	input wire logic four_lane_enable_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_load_in,
	input wire logic tx_ready_out,
	input wire logic [7:0] rx_byte_out,
	input wire logic rx_valid_out,
	input wire logic rx_is_cmd_out,
	input wire logic busy_out,
	input wire logic write_protect_out
);
	// Cycles the busy flag has stood so far.
	logic [flash_pins_pkg::BUSY_W-1:0] busy_cnt_ff;

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	////////////////////////////////////////////////////////////////////
	// Busy length counter; cleared as soon as busy drops.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_cnt_ff <= 16'h0000;
		end else if (busy_out) begin
			busy_cnt_ff <= busy_cnt_ff + 16'h0001;
		end else begin
			busy_cnt_ff <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// A taken load, and long steady levels for the protect flag.
	sequence load_s;
		tx_load_in && tx_ready_out;
	endsequence
	sequence en_held_s;
		four_lane_enable_in [*7];
	endsequence
	sequence wp_low_s;
		(!four_lane_enable_in && !data_lane_in[2]) [*7];
	endsequence

	desel_release_a: assert property (cs_n_in |-> !data_lane_oe_out)
		else $error("lanes driven while deselected");
	lane_sets_a: assert property (
		data_lane_oe_out inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("lane enable pattern not allowed");
	four_gate_a: assert property (
		data_lane_oe_out == 4'hF |-> four_lane_enable_in)
		else $error("four lanes driven while disabled");
	rx_pulse_a: assert property (rx_valid_out |=> !rx_valid_out)
		else $error("receive strobe longer than one cycle");
	tx_take_a: assert property (load_s |=> !tx_ready_out)
		else $error("ready stayed up after a load");
	busy_start_a: assert property ($rose(busy_out) |-> cs_n_in)
		else $error("busy started while selected");
	busy_len_a: assert property (
		$fell(busy_out) |-> busy_cnt_ff == BUSY_CYCLES)
		else $error("busy length wrong");
	wp_clear_a: assert property (en_held_s |-> !write_protect_out)
		else $error("protect flag up in four lane use");
	wp_set_a: assert property (wp_low_s |-> write_protect_out)
		else $error("protect flag missing");
endmodule

bind serial_flash_pin_interface flash_pins_assertions #(
	.BUSY_CYCLES(BUSY_CYCLES)
) chk (
	.mclk_in(mclk_in), .resetn_in(resetn_in), .sclk_in(sclk_in),
	.cs_n_in(cs_n_in), .data_lane_in(data_lane_in),
	.data_lane_out(data_lane_out), .data_lane_oe_out(data_lane_oe_out),
	.four_lane_enable_in(four_lane_enable_in), .tx_byte_in(tx_byte_in),
	.tx_load_in(tx_load_in), .tx_ready_out(tx_ready_out),
	.rx_byte_out(rx_byte_out), .rx_valid_out(rx_valid_out),
	.rx_is_cmd_out(rx_is_cmd_out), .busy_out(busy_out),
	.write_protect_out(write_protect_out)
);

`default_nettype wire

// ==== tb/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Host controller: mode 0, clock stands low outside frames.
module spi_host_model (
	// Resolved lane levels.
	input wire logic [3:0] lane_in,
	// Host-driven pins.
	output logic sclk_out,
	output logic cs_n_out,
	output logic [3:0] lane_out,
	output logic [3:0] lane_oe_out
);
	// Bytes read back in the last frame.
	logic [7:0] rd_q [$];

	// Select starts low, so the first frame comes before any arming.
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b0;
		lane_out = 4'hC;
		lane_oe_out = 4'hD;
	end

	// One clock pulse; data moves only while the clock is low.
	task automatic pulse();
		#32 sclk_out = 1'b1;
		#32 sclk_out = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////
	// One frame: command, write bytes or a read of nb bytes at width w.
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wr,
		input int nb, input int w, input int hold_at, input logic l3);
		logic [7:0] b;
		int i;
		int k;
		#7 cs_n_out = 1'b0;
		lane_out[3] = l3;
		for (i = 0; i < 8 * ((w == 0) ? nb + 1 : 1); i++) begin
			b = (i < 8) ? cmd : wr + 8'(i / 8 - 1);
			// Hold low with junk bits that must be ignored.
			if (i == hold_at) begin
				lane_out = {1'b0, lane_out[2:1], ~b[7 - i % 8]};
				pulse();
				pulse();
				lane_out[3] = l3;
			end
			lane_out[0] = b[7 - i % 8];
			pulse();
		end
		// Release the shared lanes before the device drives them.
		if (w > 1) begin
			lane_oe_out = (w == 4) ? 4'h0 : 4'hC;
		end
		if (w > 0) begin
			for (k = 0; k < nb * 8 / w; k++) begin
				#32 b = (w == 1) ? {b[6:0], lane_in[1]} :
					(w == 2) ? {b[5:0], lane_in[1:0]} : {b[3:0], lane_in};
				sclk_out = 1'b1;
				#32 sclk_out = 1'b0;
				if ((k + 1) % (8 / w) == 0) rd_q.push_back(b);
			end
		end
		#32 cs_n_out = 1'b1;
		// A short gap keeps the re-drive clear of the device release.
		#1 lane_oe_out = 4'hD;
		lane_out = 4'hC;
		#600;
	endtask
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Frames through the host model, core traffic checked against queues.
module tb_top;
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	int failures = 0;
	int checks = 0;
	logic sclk, cs_n, tx_load, four_en, rx_valid, rx_is_cmd, tx_ready;
	logic busy, wp, clash;
	logic noise = 1'b0;
	logic [7:0] tx_byte, rnd, rx_byte;
	logic [3:0] h_out, h_oe, d_out, d_oe, lane_w, oe_seen;
	logic [8:0] rx_q [$];
	logic [7:0] cmd_t [5] = '{8'h02, 8'h03, 8'h04, 8'h04, 8'h07};
	logic [3:0] oe_t [5] = '{4'h2, 4'h3, 4'hF, 4'h0, 4'h0};
	int w_t [5] = '{1, 2, 4, 4, 1};
	// The last entry leaves the enable set, so the link has it for
	// the frame that follows the loop.
	logic en_t [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	int i;

	// Device wins, then host; a released lane wanders.
	assign lane_w = (d_oe & d_out) | (~d_oe & h_oe & h_out) |
		(~d_oe & ~h_oe & {4{noise}});

	always #50 mclk_in = ~mclk_in;
	always @(posedge mclk_in) noise <= ~noise;
	// Lane enables seen and any contention during a frame.
	always @(posedge mclk_in) begin
		oe_seen <= oe_seen | d_oe;
		clash <= clash | (|(d_oe & h_oe));
	end
	always @(posedge mclk_in)
		if (rx_valid === 1'b1) rx_q.push_back({rx_is_cmd, rx_byte});

	serial_flash_pin_interface #(.BUSY_CYCLES(16'h0040)) DUT (
		.mclk_in(mclk_in), .resetn_in(resetn_in), .sclk_in(sclk),
		.cs_n_in(cs_n), .data_lane_in(lane_w), .data_lane_out(d_out),
		.data_lane_oe_out(d_oe), .four_lane_enable_in(four_en),
		.tx_byte_in(tx_byte), .tx_load_in(tx_load), .tx_ready_out(tx_ready),
		.rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
		.rx_is_cmd_out(rx_is_cmd), .busy_out(busy), .write_protect_out(wp));
	spi_host_model host (.lane_in(lane_w), .sclk_out(sclk), .cs_n_out(cs_n),
		.lane_out(h_out), .lane_oe_out(h_oe));

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic check(input string name, input logic [8:0] seen,
		input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Load waits for ready under a bound; a late ready fails the ready check.
	task automatic load(input logic [7:0] b);
		int n;
		for (n = 0; n < 500 && tx_ready !== 1'b1; n++) @(negedge mclk_in);
		check("ready before load", {8'h00, tx_ready}, 9'h001);
		tx_byte = b;
		tx_load = 1'b1;
		@(negedge mclk_in);
		tx_load = 1'b0;
		check("ready after load", {8'h00, tx_ready}, 9'h000);
	endtask

	// One frame; arm 0 expects no strobes, 1 checks them, 2 skips them.
	task automatic run(input logic [7:0] cmd, input int nb, input int w,
		input int hold_at, input logic l3, input logic [3:0] oe_exp,
		input int arm, input logic [7:0] exp);
		int k;
		logic [7:0] wr;
		@(negedge mclk_in);
		wr = rnd;
		oe_seen = 4'h0;
		clash = 1'b0;
		rx_q.delete();
		host.rd_q.delete();
		host.frame(cmd, wr, nb, w, hold_at, l3);
		check("lane enables", {5'h00, oe_seen}, {5'h00, oe_exp});
		check("lane clash", {8'h00, clash}, 9'h000);
		if (arm == 0) check("strobes", 9'(rx_q.size()), 9'h000);
		if (arm == 1) check("command", rx_q[0], {1'b1, cmd});
		for (k = 0; k < nb; k++) begin
			if (w == 0 && arm == 1)
				check("data", rx_q[k + 1], {1'b0, wr + 8'(k)});
			if (oe_exp != 4'h0)
				check("read", {1'b0, host.rd_q[k]}, {1'b0, exp});
		end
		rnd = lfsr(rnd);
		$display("test frame %h done", cmd);
	endtask

	initial begin
		#1000000;
		failures++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		four_en = 1'b0;
		tx_load = 1'b0;
		tx_byte = 8'h00;
		rnd = 8'h62;
		repeat (6) @(negedge mclk_in);
		resetn_in = 1'b1;
		run(flash_pins_pkg::CMD_WRITE, 1, 0, -1, 1'b1, 4'h0, 0, 8'h00);
		check("busy unarmed", {8'h00, busy}, 9'h000);
		// Hold during the command, then status while the cycle runs.
		run(flash_pins_pkg::CMD_WRITE, 2, 0, 3, 1'b1, 4'h0, 1, 8'h00);
		run(flash_pins_pkg::CMD_STATUS, 1, 1, -1, 1'b1, 4'h2, 1, 8'h01);
		for (i = 0; i < 300 && busy === 1'b1; i++) @(negedge mclk_in);
		run(flash_pins_pkg::CMD_STATUS, 1, 1, -1, 1'b1, 4'h2, 1, 8'h00);
		// Every read width, refused quad and an unknown code.
		for (i = 0; i < 5; i++) begin
			four_en = en_t[i];
			repeat (8) @(negedge mclk_in);
			load(rnd);
			run(cmd_t[i], 2, w_t[i], -1, 1'b1, oe_t[i], 2, rnd);
		end
		// Enable set: lane 3 low is data, not hold.
		run(flash_pins_pkg::CMD_WRITE, 1, 0, -1, 1'b0, 4'h0, 1, 8'h00);
		check("busy after write", {8'h00, busy}, 9'h001);
		@(negedge mclk_in);
		resetn_in = 1'b0;
		@(negedge mclk_in);
		check("busy in reset", {8'h00, busy}, 9'h000);
		resetn_in = 1'b1;
		$display("test reset done");
		four_en = 1'b0;
		host.lane_out[2] = 1'b0;
		repeat (8) @(negedge mclk_in);
		check("protect flag", {8'h00, wp}, 9'h001);
		four_en = 1'b1;
		repeat (8) @(negedge mclk_in);
		check("protect as lane", {8'h00, wp}, 9'h000);
		$display("test protect done");
		finish_test();
	end
endmodule

`default_nettype wire
